/* src/pmrs_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the rail sequencer
// Assumes: 100 MHz core clock, all delays counted in microsecond ticks
// Notes:   Included by the tick, delay and sequencer design files; the package does not include it
`ifndef PMRS_CONSTS_SVH
`define PMRS_CONSTS_SVH

// Clock and tick timing
`define PMRS_CLK_NS        10
`define PMRS_TICK_NS       1000

// Rail indices
`define PMRS_B1            0
`define PMRS_B2            1
`define PMRS_B3            2
`define PMRS_L1            3
`define PMRS_L2            4

// Serial address, 7-bit form and byte forms
`define PMRS_ADDR7         7'h25
`define PMRS_ADDR_WR       8'h4a
`define PMRS_ADDR_RD       8'h4b

// Sequencing delays in microseconds
`define PMRS_DLY_500       16'h01f4
`define PMRS_DLY_1000      16'h03e8
`define PMRS_DLY_1500      16'h05dc
`define PMRS_DLY_2000      16'h07d0
`define PMRS_DLY_ZERO      16'h0000
`define PMRS_EXT_US        2500
`define PMRS_RST1_US       20000
`define PMRS_RST2_US       60000

// Register offsets
`define PMRS_OFS_ID        8'h00
`define PMRS_OFS_CTRL      8'h04
`define PMRS_OFS_STAT      8'h08
`define PMRS_OFS_ICLR      8'h0c
`define PMRS_OFS_IEN       8'h10
`define PMRS_OFS_NORM      8'h14
`define PMRS_OFS_SCAL      8'h18
`define PMRS_OFS_LDO       8'h1c
`define PMRS_OFS_STATE     8'h20
`define PMRS_OFS_VOLT      8'h24

// Sleep control field positions and reset value
`define PMRS_CTRL_SLP_KIND 0
`define PMRS_CTRL_SLP_EN   1
`define PMRS_CTRL_SLP_REQ  2
`define PMRS_CTRL_DSL_KIND 3
`define PMRS_CTRL_DSL_EN   4
`define PMRS_CTRL_DSL_REQ  5
`define PMRS_CTRL_RST      6'h08

// Status bit positions
`define PMRS_ST_SEQ_DONE   0
`define PMRS_ST_PG_LOST    1
`define PMRS_ST_OUTSIDE_POWER_GOOD_IN     2
`define PMRS_ST_SHDN       3

// Voltage code arithmetic, 10 uV units: 0.8 V base, 12.5 mV step
`define PMRS_V_BASE        20'h13880
`define PMRS_V_STEP        20'h004e2

// Voltage code defaults per configuration
`define PMRS_C1_NORM       24'h1c50c8
`define PMRS_C1_SCAL       24'h0850c8
`define PMRS_C1_LDO        16'h50c8
`define PMRS_C2_NORM       24'hc85020
`define PMRS_C2_SCAL       24'hc85020
`define PMRS_C2_LDO        16'hc888

`endif

/* src/pmrs_pkg.sv */
// Purpose: Types shared by the rail sequencer files
// Assumes: Nothing beyond the constants header
// Notes:   One-hot sequencer states
package pmrs_pkg;

	// Top level sequencer states
	typedef enum logic [5:0] {
		ST_OFF   = 6'h01,
		ST_START = 6'h02,
		ST_ACT   = 6'h04,
		ST_SLEEP = 6'h08,
		ST_DEEP  = 6'h10,
		ST_SHDN  = 6'h20
	} pmrs_state_e;

	// Voltage codes of the three step-down rails
	typedef struct packed {
		logic [7:0] b3;
		logic [7:0] b2;
		logic [7:0] b1;
	} pmrs_vcode_s;

	typedef logic [15:0] pmrs_dly_t;

endpackage

/* src/pmrs_tick.sv */
// Purpose: Microsecond tick divider
// Assumes: TICK_CYCLES at least one
// Notes:   Tick is a one-cycle enable pulse
`timescale 1ns/1ps
`include "pmrs_consts.svh"
module pmrs_tick
	import pmrs_pkg::*;
#(
	parameter logic [15:0] TICK_CYCLES = 16'(`PMRS_TICK_NS / `PMRS_CLK_NS)
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	output logic      tick_o
);

	logic [15:0] cnt;
	wire         wrap = (cnt == TICK_CYCLES - 16'h0001);

	// Free running divider
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt    <= 16'h0000;
			tick_o <= 1'b0;
		end else begin
			cnt    <= wrap ? 16'h0000 : cnt + 16'h0001;
			tick_o <= wrap;
		end
	end

endmodule

/* src/pmrs_delay.sv */
// Purpose: Trigger-to-start delay counter in microsecond ticks
// Assumes: Start held high while the trigger stands
// Notes:   Dropping start clears the count
`timescale 1ns/1ps
`include "pmrs_consts.svh"
module pmrs_delay
	import pmrs_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      rstn_i,
	input  wire logic      tick_i,
	input  wire logic      start_i,
	input  wire pmrs_dly_t dly_i,
	output logic           done_o
);

	pmrs_dly_t cnt;
	wire       reached = (cnt >= dly_i);

	// Count ticks only while started
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt    <= 16'h0000;
			done_o <= 1'b0;
		end else if (!start_i) begin
			cnt    <= 16'h0000;
			done_o <= 1'b0;
		end else begin
			done_o <= reached;
			if (tick_i && !reached)
				cnt <= cnt + 16'h0001;
		end
	end

endmodule

/* src/pmrs_seq.sv */
// Purpose: Rail sequencer with status pins, sleep defaults and voltage code selection
// Assumes: Analog rails report power-good on RAIL_PG_I; strap picks the configuration
// Notes:   All delays counted in microsecond ticks from pmrs_tick
`timescale 1ns/1ps
`include "pmrs_consts.svh"
module pmrs_seq
	import pmrs_pkg::*;
#(
	parameter logic [15:0] TICK_CYCLES = 16'(`PMRS_TICK_NS / `PMRS_CLK_NS),
	parameter logic [15:0] EXT_US      = 16'(`PMRS_EXT_US),
	parameter logic [15:0] RST1_US     = 16'(`PMRS_RST1_US),
	parameter logic [15:0] RST2_US     = 16'(`PMRS_RST2_US)
) (
	input  wire logic        MCLK_I,
	input  wire logic        RSTN_I,
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic      [31:0] REG_RDATA_O,
	input  wire logic        INPUT_UNDERVOLTAGE_RELEASE_I,
	input  wire logic        FACTORY_CONFIG_OPTION_I,
	input  wire logic [4:0]  RAIL_PG_I,
	input  wire logic        OUTSIDE_POWER_GOOD_IN_I,
	input  wire logic        VOLTAGE_SCALING_SELECT_I,
	output logic      [4:0]  RAIL_EN_O,
	output logic             LOAD_SWITCH_ONE_EN_O,
	output pmrs_vcode_s      BUCK_VCODE_O,
	output logic      [15:0] LDO_VCODE_O,
	output logic             SYS_RST_OUT_LOW_O,
	output logic             SYS_RST_OUT_LOW_OE_O,
	output logic             OUTSIDE_SUPPLY_ENABLE_O,
	output logic             OUTSIDE_SUPPLY_ENABLE_OE_O,
	output logic             INTERRUPT_OUT_LOW_O,
	output logic             INTERRUPT_OUT_LOW_OE_O
);

	// Voltage code to level in 10 uV units
	function automatic logic [19:0] vcode_level(input logic [7:0] code);
		vcode_level = `PMRS_V_BASE + (20'(code) * `PMRS_V_STEP);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, change taken when stages two and three agree
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] sy1;
	logic [NSYNC-1:0] sy2;
	logic [NSYNC-1:0] sy3;
	logic [NSYNC-1:0] pin;
	wire  [NSYNC-1:0] raw = {FACTORY_CONFIG_OPTION_I, VOLTAGE_SCALING_SELECT_I, OUTSIDE_POWER_GOOD_IN_I,
	                         INPUT_UNDERVOLTAGE_RELEASE_I, RAIL_PG_I};
	wire  [NSYNC-1:0] agree = ~(sy2 ^ sy3);

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sy1 <= '0;
			sy2 <= '0;
			sy3 <= '0;
			pin <= '0;
		end else begin
			sy1 <= raw;
			sy2 <= sy1;
			sy3 <= sy2;
			pin <= (pin & ~agree) | (sy3 & agree);
		end
	end

	wire [4:0] pg      = pin[4:0];
	wire       uvlo_ok = pin[5];
	wire       outside_power_good_in  = pin[6];
	wire       voltage_scaling_select     = pin[7];
	wire       strap   = pin[8];

	////////////////////////////////////////////////////////////////////////
	// Configuration strap caught once after reset release
	logic       cfg2;
	logic       cfg_done;
	logic [2:0] cfg_wait;

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cfg2     <= 1'b0;
			cfg_done <= 1'b0;
			cfg_wait <= 3'h0;
		end else if (!cfg_done) begin
			// Wait until the synchronised strap has settled
			cfg_wait <= cfg_wait + 3'h1;
			if (cfg_wait == 3'h5) begin
				cfg2     <= strap;
				cfg_done <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file state
	logic [5:0]  ctrl;
	logic [3:0]  stat;
	logic [3:0]  ien;
	pmrs_vcode_s norm;
	pmrs_vcode_s scal;
	logic [15:0] ldo;
	logic        dflt_done;

	wire wr_ctrl = REG_WR_I && (REG_ADDR_I == `PMRS_OFS_CTRL);
	wire wr_iclr = REG_WR_I && (REG_ADDR_I == `PMRS_OFS_ICLR);
	wire wr_ien  = REG_WR_I && (REG_ADDR_I == `PMRS_OFS_IEN);
	wire wr_norm = REG_WR_I && (REG_ADDR_I == `PMRS_OFS_NORM);
	wire wr_scal = REG_WR_I && (REG_ADDR_I == `PMRS_OFS_SCAL);
	wire wr_ldo  = REG_WR_I && (REG_ADDR_I == `PMRS_OFS_LDO);

	////////////////////////////////////////////////////////////////////////
	// Sequencer state and timers
	pmrs_state_e state;
	pmrs_state_e next_state;
	logic [4:0]  rail_on;
	logic [15:0] sd_cnt;
	logic        tick;
	logic [4:0]  su_done;
	logic        ext_done;
	logic        rst_done;

	wire run     = state[1] | state[2] | state[3] | state[4];
	wire slp_go  = ctrl[`PMRS_CTRL_SLP_EN] & ctrl[`PMRS_CTRL_SLP_REQ];
	wire dsl_go  = ctrl[`PMRS_CTRL_DSL_EN] & ctrl[`PMRS_CTRL_DSL_REQ];

	pmrs_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_i (MCLK_I),
		.rstn_i(RSTN_I),
		.tick_o(tick)
	);

	// Trigger power-good per rail, chosen by configuration
	wire [4:0] trig;
	assign trig[`PMRS_B1] = cfg2 ? outside_power_good_in : pg[`PMRS_B3];
	assign trig[`PMRS_B2] = cfg2 ? pg[`PMRS_L2] : pg[`PMRS_B1];
	assign trig[`PMRS_B3] = cfg2 ? 1'b1 : pg[`PMRS_L1];
	assign trig[`PMRS_L1] = cfg2 ? pg[`PMRS_B1] : 1'b1;
	assign trig[`PMRS_L2] = cfg2 ? pg[`PMRS_B3] : 1'b1;

	// Start-up and shutdown delays per rail
	pmrs_dly_t su_dly [5];
	pmrs_dly_t sd_dly [5];
	assign su_dly[`PMRS_B1] = cfg2 ? `PMRS_DLY_ZERO : `PMRS_DLY_500;
	assign su_dly[`PMRS_B2] = `PMRS_DLY_500;
	assign su_dly[`PMRS_B3] = cfg2 ? `PMRS_DLY_ZERO : `PMRS_DLY_500;
	assign su_dly[`PMRS_L1] = cfg2 ? `PMRS_DLY_500 : `PMRS_DLY_ZERO;
	assign su_dly[`PMRS_L2] = cfg2 ? `PMRS_DLY_500 : `PMRS_DLY_ZERO;
	assign sd_dly[`PMRS_B1] = `PMRS_DLY_500;
	assign sd_dly[`PMRS_B2] = cfg2 ? `PMRS_DLY_500 : `PMRS_DLY_ZERO;
	assign sd_dly[`PMRS_B3] = cfg2 ? `PMRS_DLY_500 : `PMRS_DLY_1000;
	assign sd_dly[`PMRS_L1] = cfg2 ? `PMRS_DLY_ZERO : `PMRS_DLY_2000;
	assign sd_dly[`PMRS_L2] = cfg2 ? `PMRS_DLY_500 : `PMRS_DLY_1500;

	// Delay counter per rail, started by its trigger power-good
	for (genvar i = 0; i < 5; i++) begin : g_rail
		pmrs_delay u_dly (
			.clk_i  (MCLK_I),
			.rstn_i (RSTN_I),
			.tick_i (tick),
			.start_i(run & trig[i] & ~rail_on[i]),
			.dly_i  (su_dly[i]),
			.done_o (su_done[i])
		);
	end

	// Outside supply enable delay after rail two is good
	pmrs_delay u_ext (
		.clk_i  (MCLK_I),
		.rstn_i (RSTN_I),
		.tick_i (tick),
		.start_i(run & pg[`PMRS_B2]),
		.dly_i  (EXT_US),
		.done_o (ext_done)
	);

	// System reset release delay
	pmrs_delay u_rst (
		.clk_i  (MCLK_I),
		.rstn_i (RSTN_I),
		.tick_i (tick),
		.start_i(run & (cfg2 ? pg[`PMRS_L1] : pg[`PMRS_B3])),
		.dly_i  (cfg2 ? RST2_US : RST1_US),
		.done_o (rst_done)
	);

	// Shutdown release per rail, timed from shutdown start
	wire [4:0] sd_off;
	for (genvar i = 0; i < 5; i++) begin : g_sd
		assign sd_off[i] = state[5] & (sd_cnt >= sd_dly[i]);
	end

	// State transitions
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF:   if (cfg_done && dflt_done && uvlo_ok) next_state = ST_START;
			ST_START: if (!uvlo_ok) next_state = ST_SHDN;
			          else if (&rail_on) next_state = ST_ACT;
			ST_ACT:   if (!uvlo_ok) next_state = ST_SHDN;
			          else if (dsl_go) next_state = ST_DEEP;
			          else if (slp_go) next_state = ST_SLEEP;
			ST_SLEEP: if (!uvlo_ok) next_state = ST_SHDN;
			          else if (dsl_go) next_state = ST_DEEP;
			          else if (!slp_go) next_state = ST_ACT;
			ST_DEEP:  if (!uvlo_ok) next_state = ST_SHDN;
			          else if (!dsl_go) next_state = ST_ACT;
			ST_SHDN:  if (rail_on == 5'h00) next_state = ST_OFF;
			default:  next_state = ST_OFF;
		endcase
	end

	// Rails one and two off in sleep states for config one; config two keeps all on
	wire        low_pwr   = state[3] | state[4];
	wire [4:0]  slp_mask  = (low_pwr && !cfg2) ? 5'h03 : 5'h00;
	wire [4:0]  next_rail = state[5] ? (rail_on & ~sd_off) : (rail_on | (su_done & {5{run}}));

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state   <= ST_OFF;
			rail_on <= 5'h00;
			sd_cnt  <= 16'h0000;
		end else begin
			state   <= next_state;
			rail_on <= next_rail;
			if (!state[5])
				sd_cnt <= 16'h0000;
			else if (tick && sd_cnt != 16'hffff)
				sd_cnt <= sd_cnt + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Events, sticky status with set winning over clear
	logic      pg_d;
	logic      outside_power_good_in_d;
	logic      rst_d;
	wire [3:0] ev;
	assign ev[`PMRS_ST_SEQ_DONE] = rst_done & ~rst_d;
	assign ev[`PMRS_ST_PG_LOST]  = |(rail_on & ~pg) & state[2] & pg_d;
	assign ev[`PMRS_ST_OUTSIDE_POWER_GOOD_IN]   = outside_power_good_in & ~outside_power_good_in_d;
	assign ev[`PMRS_ST_SHDN]     = (next_state == ST_SHDN) & ~state[5];
	wire [3:0] clr = wr_iclr ? REG_WDATA_I[3:0] : 4'h0;

	// Register writes; voltage defaults follow the caught strap
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ctrl      <= `PMRS_CTRL_RST;
			stat      <= 4'h0;
			ien       <= 4'h0;
			norm      <= '0;
			scal      <= '0;
			ldo       <= 16'h0000;
			dflt_done <= 1'b0;
			pg_d      <= 1'b0;
			outside_power_good_in_d  <= 1'b0;
			rst_d     <= 1'b0;
		end else begin
			pg_d     <= &(pg | ~rail_on);
			outside_power_good_in_d <= outside_power_good_in;
			rst_d    <= rst_done;
			stat     <= (stat & ~clr) | ev;
			if (wr_ctrl)
				ctrl <= REG_WDATA_I[5:0];
			if (wr_ien)
				ien <= REG_WDATA_I[3:0];
			if (cfg_done && !dflt_done) begin
				dflt_done <= 1'b1;
				norm      <= cfg2 ? `PMRS_C2_NORM : `PMRS_C1_NORM;
				scal      <= cfg2 ? `PMRS_C2_SCAL : `PMRS_C1_SCAL;
				ldo       <= cfg2 ? `PMRS_C2_LDO : `PMRS_C1_LDO;
			end else begin
				if (wr_norm)
					norm <= REG_WDATA_I[23:0];
				if (wr_scal)
					scal <= REG_WDATA_I[23:0];
				if (wr_ldo)
					ldo <= REG_WDATA_I[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read decode
	pmrs_vcode_s act_code;
	assign act_code = voltage_scaling_select ? norm : scal;
	wire [19:0] b1_lvl = vcode_level(act_code.b1);
	wire [19:0] l1_lvl = vcode_level(ldo[7:0]);
	logic [31:0] rd_mux;
	always_comb begin
		case (REG_ADDR_I)
			`PMRS_OFS_ID:    rd_mux = {8'h00, `PMRS_ADDR_RD, `PMRS_ADDR_WR, 1'b0, `PMRS_ADDR7};
			`PMRS_OFS_CTRL:  rd_mux = {26'h0, ctrl};
			`PMRS_OFS_STAT:  rd_mux = {28'h0, stat};
			`PMRS_OFS_IEN:   rd_mux = {28'h0, ien};
			`PMRS_OFS_NORM:  rd_mux = {8'h00, norm};
			`PMRS_OFS_SCAL:  rd_mux = {8'h00, scal};
			`PMRS_OFS_LDO:   rd_mux = {16'h0000, ldo};
			`PMRS_OFS_STATE: rd_mux = {10'h0, cfg2, voltage_scaling_select, outside_power_good_in, uvlo_ok, pg, rail_on, 2'h0, state};
			`PMRS_OFS_VOLT:  rd_mux = {6'h0, l1_lvl[12:0], b1_lvl[12:0]};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Output flops
	wire irq = |(stat & ien);
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			REG_RDATA_O                <= 32'h0000_0000;
			RAIL_EN_O                  <= 5'h00;
			LOAD_SWITCH_ONE_EN_O       <= 1'b0;
			BUCK_VCODE_O               <= '0;
			LDO_VCODE_O                <= 16'h0000;
			SYS_RST_OUT_LOW_O          <= 1'b0;
			SYS_RST_OUT_LOW_OE_O       <= 1'b1;
			OUTSIDE_SUPPLY_ENABLE_O    <= 1'b0;
			OUTSIDE_SUPPLY_ENABLE_OE_O <= 1'b1;
			INTERRUPT_OUT_LOW_O        <= 1'b0;
			INTERRUPT_OUT_LOW_OE_O     <= 1'b0;
		end else begin
			REG_RDATA_O                <= REG_RD_I ? rd_mux : 32'h0000_0000;
			RAIL_EN_O                  <= next_rail & ~slp_mask;
			LOAD_SWITCH_ONE_EN_O       <= 1'b0;
			BUCK_VCODE_O               <= act_code;
			LDO_VCODE_O                <= ldo;
			SYS_RST_OUT_LOW_OE_O       <= ~(rst_done & ~state[5]);
			OUTSIDE_SUPPLY_ENABLE_OE_O <= ~(ext_done & ~state[5]);
			INTERRUPT_OUT_LOW_OE_O     <= irq;
		end
	end

endmodule

/* tb/pmrs_seq_asserts.sv */
// Purpose: Port-level timing checks for the rail sequencer
// Assumes: Strap pin only changes while reset is held
// Notes:   Windows allow 14 cycles of sync and register slack
`timescale 1ns/1ps
module pmrs_seq_asserts
	import pmrs_pkg::*;
#(
	parameter logic [15:0] TICK_CYCLES = 16'h0064,
	parameter logic [15:0] EXT_US      = 16'h09c4,
	parameter logic [15:0] RST1_US     = 16'h4e20,
	parameter logic [15:0] RST2_US     = 16'hea60
) (
	input wire logic       MCLK_I,
	input wire logic       RSTN_I,
	input wire logic       INPUT_UNDERVOLTAGE_RELEASE_I,
	input wire logic       FACTORY_CONFIG_OPTION_I,
	input wire logic [4:0] RAIL_PG_I,
	input wire logic       OUTSIDE_POWER_GOOD_IN_I,
	input wire logic [4:0] RAIL_EN_O,
	input wire logic       LOAD_SWITCH_ONE_EN_O,
	input wire logic       SYS_RST_OUT_LOW_O,
	input wire logic       SYS_RST_OUT_LOW_OE_O,
	input wire logic       OUTSIDE_SUPPLY_ENABLE_O,
	input wire logic       OUTSIDE_SUPPLY_ENABLE_OE_O,
	input wire logic       INTERRUPT_OUT_LOW_O
);
	logic [6:0] watch;
	logic [4:0] seen;
	logic       cfg2;
	int         run [7];

	// Watched pins: rail power-good, outside power-good, input low
	assign watch = {~INPUT_UNDERVOLTAGE_RELEASE_I, OUTSIDE_POWER_GOOD_IN_I, RAIL_PG_I};
	assign cfg2  = FACTORY_CONFIG_OPTION_I;

	// Consecutive high cycles per pin, and rails ever enabled
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			seen <= 5'h00;
			for (int i = 0; i < 7; i++)
				run[i] <= 0;
		end else begin
			seen <= seen | RAIL_EN_O;
			for (int i = 0; i < 7; i++)
				run[i] <= watch[i] ? run[i] + 1 : 0;
		end
	end

	// Count lies within a microsecond figure plus slack
	function automatic bit in_win(input int cnt, input int us);
		return cnt >= us * int'(TICK_CYCLES) && cnt <= us * int'(TICK_CYCLES) + 14;
	endfunction

	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);

	////////////////////////////////////////////////////////////////////////////////
	property p_lin_first;
		$rose(RAIL_EN_O[3]) && !seen[3] && !cfg2 |-> INPUT_UNDERVOLTAGE_RELEASE_I && RAIL_EN_O[2:0] == 3'h0;
	endproperty
	a_lin_first: assert property (p_lin_first) else $error("linear rail one not first");
	property p_b3_start;
		$rose(RAIL_EN_O[2]) && !seen[2] && !cfg2 |-> in_win(run[3], 500);
	endproperty
	a_b3_start: assert property (p_b3_start) else $error("rail three start delay");
	property p_b2_start;
		$rose(RAIL_EN_O[1]) && !seen[1] && !cfg2 |-> in_win(run[0], 500) && RAIL_EN_O[2];
	endproperty
	a_b2_start: assert property (p_b2_start) else $error("rail two start delay");
	property p_b1_ext;
		$rose(RAIL_EN_O[0]) && !seen[0] && cfg2 |-> in_win(run[5], 0) && !RAIL_EN_O[3];
	endproperty
	a_b1_ext: assert property (p_b1_ext) else $error("rail one not from outside good");
	property p_rst_c1;
		$fell(SYS_RST_OUT_LOW_OE_O) && !cfg2 |-> in_win(run[2], RST1_US);
	endproperty
	a_rst_c1: assert property (p_rst_c1) else $error("reset release time config one");
	property p_rst_c2;
		$fell(SYS_RST_OUT_LOW_OE_O) && cfg2 |-> in_win(run[3], RST2_US);
	endproperty
	a_rst_c2: assert property (p_rst_c2) else $error("reset release time config two");
	property p_ext_rel;
		$fell(OUTSIDE_SUPPLY_ENABLE_OE_O) |-> in_win(run[1], EXT_US);
	endproperty
	a_ext_rel: assert property (p_ext_rel) else $error("outside enable time");
	property p_sd_b3;
		$fell(RAIL_EN_O[2]) && !cfg2 && run[6] > 0 |-> in_win(run[6], 1000);
	endproperty
	a_sd_b3: assert property (p_sd_b3) else $error("rail three off time");
	property p_sd_l1;
		$fell(RAIL_EN_O[3]) && !cfg2 && run[6] > 0 |-> in_win(run[6], 2000);
	endproperty
	a_sd_l1: assert property (p_sd_l1) else $error("linear rail one off time");
	property p_sd_b2;
		$fell(RAIL_EN_O[1]) && !cfg2 && run[6] > 0 |-> in_win(run[6], 0) && RAIL_EN_O[3];
	endproperty
	a_sd_b2: assert property (p_sd_b2) else $error("rail two off time");
	property p_pins;
		!INTERRUPT_OUT_LOW_O && !SYS_RST_OUT_LOW_O && !OUTSIDE_SUPPLY_ENABLE_O && !LOAD_SWITCH_ONE_EN_O;
	endproperty
	a_pins: assert property (p_pins) else $error("open-drain level or load switch");
endmodule

bind pmrs_seq pmrs_seq_asserts #(
	.TICK_CYCLES(TICK_CYCLES), .EXT_US(EXT_US), .RST1_US(RST1_US), .RST2_US(RST2_US)
) chk_u (
	.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .INPUT_UNDERVOLTAGE_RELEASE_I(INPUT_UNDERVOLTAGE_RELEASE_I),
	.FACTORY_CONFIG_OPTION_I(FACTORY_CONFIG_OPTION_I), .RAIL_PG_I(RAIL_PG_I),
	.OUTSIDE_POWER_GOOD_IN_I(OUTSIDE_POWER_GOOD_IN_I), .RAIL_EN_O(RAIL_EN_O),
	.LOAD_SWITCH_ONE_EN_O(LOAD_SWITCH_ONE_EN_O), .SYS_RST_OUT_LOW_O(SYS_RST_OUT_LOW_O),
	.SYS_RST_OUT_LOW_OE_O(SYS_RST_OUT_LOW_OE_O), .OUTSIDE_SUPPLY_ENABLE_O(OUTSIDE_SUPPLY_ENABLE_O),
	.OUTSIDE_SUPPLY_ENABLE_OE_O(OUTSIDE_SUPPLY_ENABLE_OE_O), .INTERRUPT_OUT_LOW_O(INTERRUPT_OUT_LOW_O)
);

/* tb/pmrs_rail_model.sv */
// Purpose: Far-side model of the rails and the outside supply
// Assumes: Outside enable wire has a pull-up and feeds the supply
// Notes:   Slow mode stretches every power-good lag
`timescale 1ns/1ps
module pmrs_rail_model (
	input  wire logic       clk_i,
	input  wire logic       slow_i,
	input  wire logic [4:0] rail_en_i,
	input  wire logic       ext_oe_i,
	output logic      [4:0] rail_pg_o,
	output logic            outside_power_good_in_o
);
	logic [5:0] on;
	logic [5:0] good;
	int         lag;
	int         age [6] = '{default: 0};

	// Released open-drain enable reads high through the pull-up
	assign on  = {~ext_oe_i, rail_en_i};
	assign lag = slow_i ? 40 : 3;
	assign {outside_power_good_in_o, rail_pg_o} = good;

	// Cycles each supply has been enabled
	always @(posedge clk_i) begin
		for (int i = 0; i < 6; i++)
			age[i] <= on[i] ? age[i] + 1 : 0;
	end

	// Good after the lag, lost at once when disabled
	always_comb begin
		for (int i = 0; i < 6; i++)
			good[i] = on[i] && age[i] >= lag;
	end
endmodule

/* tb/pmrs_seq_tb.sv */
// Purpose: Self-checking bench for the rail sequencer
// Assumes: One-cycle tick and shortened reset and supply counts
// Notes:   Rail model closes the power-good loop
`timescale 1ns/1ps
module pmrs_seq_tb
	import pmrs_pkg::*;
;
	typedef struct {
		logic [7:0]  addr;
		bit          wr;
		logic [31:0] wdata;
		logic [31:0] exp;
		logic        irq;
	} pmrs_row_s;

	logic        mclk = 1'b0;
	logic        rstn, wr, rd, uvlo, cfg, voltage_scaling_select, slow;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, val;
	logic [4:0]  pg, en;
	logic        outside_power_good_in, ls, rst_d, rst_oe, ext_d, ext_oe, irq_d, irq_oe;
	pmrs_vcode_s bvc;
	logic [15:0] lvc;
	logic [31:0] slp [2] = '{32'h0e, 32'h38};
	pmrs_row_s   rows [11];
	int          err_count = 0;
	int          cmp_count = 0;

	////////////////////////////////////////////////////////////////////////////////
	always #5 mclk = ~mclk;

	pmrs_seq #(.TICK_CYCLES(16'h0001), .EXT_US(16'h000a), .RST1_US(16'h0014), .RST2_US(16'h001e)) dut_u (
		.MCLK_I(mclk), .RSTN_I(rstn), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_RDATA_O(rdata), .INPUT_UNDERVOLTAGE_RELEASE_I(uvlo),
		.FACTORY_CONFIG_OPTION_I(cfg), .RAIL_PG_I(pg), .OUTSIDE_POWER_GOOD_IN_I(outside_power_good_in),
		.VOLTAGE_SCALING_SELECT_I(voltage_scaling_select), .RAIL_EN_O(en), .LOAD_SWITCH_ONE_EN_O(ls), .BUCK_VCODE_O(bvc),
		.LDO_VCODE_O(lvc), .SYS_RST_OUT_LOW_O(rst_d), .SYS_RST_OUT_LOW_OE_O(rst_oe),
		.OUTSIDE_SUPPLY_ENABLE_O(ext_d), .OUTSIDE_SUPPLY_ENABLE_OE_O(ext_oe),
		.INTERRUPT_OUT_LOW_O(irq_d), .INTERRUPT_OUT_LOW_OE_O(irq_oe)
	);

	pmrs_rail_model rm_u (
		.clk_i(mclk), .slow_i(slow), .rail_en_i(en), .ext_oe_i(ext_oe), .rail_pg_o(pg), .outside_power_good_in_o(outside_power_good_in)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle register write
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask

	// One-cycle register read, data taken in the following cycle
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask

	// Bounded wait for a rail enable pattern
	task automatic wait_rails(input logic [4:0] want, input int n);
		for (int k = 0; k < n && en !== want; k++)
			@(posedge mclk);
		@(negedge mclk);
	endtask

	// Low 13 bits of the level in 10 uV units
	function automatic logic [12:0] v13(input logic [7:0] code);
		return 13'(80000 + 1250 * int'(code));
	endfunction

	task automatic give_verdict;
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (30000) @(posedge mclk);
		err_count++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rows = '{
			'{8'h00, 0, 32'h0, 32'h004b4a25, 1'b0}, '{8'h04, 0, 32'h0, 32'h08, 1'b0},
			'{8'h00, 1, 32'hffffffff, 32'h004b4a25, 1'b0}, '{8'h30, 0, 32'h0, 32'h0, 1'b0},
			'{8'h10, 1, 32'h1, 32'h1, 1'b1}, '{8'h0c, 1, 32'h1, 32'h0, 1'b0},
			'{8'h10, 1, 32'h4, 32'h4, 1'b1}, '{8'h10, 1, 32'h0, 32'h0, 1'b0},
			'{8'h08, 0, 32'h0, 32'h4, 1'b0}, '{8'h0c, 1, 32'hf, 32'h0, 1'b0},
			'{8'h08, 0, 32'h0, 32'h0, 1'b0}
		};
		{rstn, wr, rd, uvlo, cfg, voltage_scaling_select, slow} = 7'b0000010;
		addr  = 8'h00;
		wdata = 32'h0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk(32'({en, rst_oe, ext_oe, irq_oe}), 32'h6);
		@(posedge mclk);
		rstn <= 1'b1;
		repeat (10) @(posedge mclk);
		uvlo <= 1'b1;
		wait_rails(5'h1f, 6000);
		repeat (40) @(posedge mclk);
		chk(32'({en, rst_oe, ext_oe}), 32'h7c);
		// Register and interrupt table
		foreach (rows[i]) begin
			if (rows[i].wr)
				reg_wr(rows[i].addr, rows[i].wdata);
			reg_rd(rows[i].addr, val);
			chk(val, rows[i].exp);
			chk(32'(irq_oe), 32'(rows[i].irq));
		end
		// Scaling select: rail three codes for 1.15 V and 0.9 V
		@(posedge mclk);
		voltage_scaling_select <= 1'b0;
		repeat (10) @(posedge mclk);
		chk(32'(bvc.b3), 32'd8);
		voltage_scaling_select <= 1'b1;
		repeat (10) @(posedge mclk);
		chk(32'(bvc.b3), 32'd28);
		reg_wr(8'h14, 32'h001c5000);
		reg_wr(8'h1c, 32'h000050ff);
		reg_rd(8'h24, val);
		chk(val, {6'h0, v13(8'hff), v13(8'h00)});
		chk(32'(bvc.b1), 32'h0);
		chk(32'(lvc), 32'h50ff);
		// Sleep and deep sleep drop rails one and two only
		foreach (slp[j]) begin
			reg_wr(8'h04, slp[j]);
			repeat (10) @(posedge mclk);
			chk(32'({en, ls}), 32'h38);
			reg_wr(8'h04, 32'h8);
			wait_rails(5'h1f, 200);
			chk(32'(en), 32'h1f);
		end
		// Shutdown
		@(posedge mclk);
		uvlo <= 1'b0;
		wait_rails(5'h00, 4000);
		reg_rd(8'h08, val);
		chk(32'({en, rst_oe, ext_oe}), 32'h3);
		chk(val & 32'h8, 32'h8);
		// Second configuration, slow rails
		@(posedge mclk);
		rstn <= 1'b0;
		cfg  <= 1'b1;
		slow <= 1'b1;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		repeat (10) @(posedge mclk);
		uvlo <= 1'b1;
		wait_rails(5'h17, 6000);
		chk(32'({en, ext_oe}), 32'h2e);
		wait_rails(5'h1f, 2000);
		repeat (100) @(posedge mclk);
		chk(32'({en, rst_oe}), 32'h3e);
		give_verdict();
	end
endmodule
